// file: verilog/psd_strap_mapper.sv
// Strap capture, EEPROM override and Avalon-MM register file for port 2 and port 0 defaults
//
// Functional notes
// - Port 2 speed low bit defaults from the port 2 speed strap, which defaults high.
// - Speed strap also sets port 2 ten-meg advertisement bits and mode field.
// - Auto-negotiation strap also shapes speed, duplex, ten-meg advertisement and mode defaults.
// - Duplex strap, default high, sets duplex bit, ten-meg full advertisement and mode.
// - Backpressure strap, default high, sets port 2 backpressure enable default.
// - Flow control strap, default high, sets both port 2 pause enable defaults.
// - Flow control strap also shapes the advertised asymmetric pause default.
// - Manual flow control strap, default low, sets the manual select default.
// - Manual flow control strap also sets advertised symmetric and asymmetric pause defaults.
// - Port 0 speed strap, default high, sets virtual partner ability defaults.
// - When virtual auto-negotiation fails, port 0 runs at the strapped speed.
// - EEPROM loader may replace soft straps; hard straps latch only at reset.
module psd_strap_mapper (
	input  wire  logic                         clk_sys,
	input  wire  logic                         reset,
	input  wire  psd_pkg::psd_strap_t          strap_pins,
	input  wire  logic [1:0]                   hard_pins,
	input  wire  logic                         eeprom_valid,
	input  wire  psd_pkg::psd_strap_t          eeprom_straps,
	input  wire  logic                         vphy_an_fail,
	input  wire  logic                         vphy_an_speed_100,
	input  wire  logic [psd_pkg::ADDR_W-1:0]   avs_address,
	input  wire  logic                         avs_read,
	input  wire  logic                         avs_write,
	input  wire  logic [31:0]                  avs_writedata,
	input  wire  logic [3:0]                   avs_byteenable,
	output logic [31:0]                        avs_readdata,
	output logic                               avs_waitrequest,
	output logic [1:0]                         avs_response,
	output psd_pkg::psd_cfg_t                  cfg_out,
	output logic [1:0]                         hard_out,
	output logic                               p0_speed_100
);
	import psd_pkg::*;

	psd_strap_t  strap_reg;
	logic [1:0]  hard_reg;
	psd_cfg_t    cfg_reg;
	logic        pending_reg;
	logic        an_fail_reg;
	logic        p0_speed_reg;
	logic        wait_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  resp_reg;

	psd_strap_t  map_in;
	psd_cfg_t    dflt;
	logic        load;
	logic        req;
	logic        commit;
	logic        wr_commit;
	logic        lane0;
	logic        hit;
	logic [31:0] rd_word;

	// Widen a narrow field into a read word
	function automatic logic [31:0] zext4(input logic [3:0] v);
		return {28'h0000000, v};
	endfunction

	// Bus request accepted at the edge where waitrequest is low
	assign req       = avs_read | avs_write;
	assign commit    = req & ~wait_reg;
	assign wr_commit = avs_write & ~wait_reg;
	assign lane0     = avs_byteenable[0];

	// First cycle after reset takes the pins; later an EEPROM load replaces them
	assign map_in = pending_reg ? strap_pins : eeprom_straps;
	assign load   = pending_reg | eeprom_valid;

	psd_default_map u_map (
		.straps (map_in),
		.dflt   (dflt)
	);

	// Pin capture waits one cycle past reset so reset never loads a port value
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pending_reg <= 1'b1;
		end else begin
			pending_reg <= 1'b0;
		end
	end

	// Soft straps: pins after reset, EEPROM afterwards
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			strap_reg <= STRAP_RESET;
		end else if (load) begin
			strap_reg <= map_in;
		end
	end

	// Hard straps latch once; the EEPROM cannot reach them
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			hard_reg <= HARD_RESET;
		end else if (pending_reg) begin
			hard_reg <= hard_pins;
		end
	end

	// Config registers: defaults on load, software writes otherwise
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cfg_reg <= CFG_RESET;
		end else if (load) begin
			// Load wins over a write in the same cycle so the new defaults are consistent
			cfg_reg <= dflt;
		end else if (wr_commit && lane0) begin
			case (avs_address)
				OFS_BASIC:    cfg_reg.basic    <= avs_writedata[2:0];
				OFS_ADVERT:   cfg_reg.advert   <= avs_writedata[3:0];
				OFS_SPECIAL:  cfg_reg.mode     <= avs_writedata[2:0];
				OFS_PAUSE:    cfg_reg.pause    <= avs_writedata[3:0];
				OFS_VPARTNER: cfg_reg.vpartner <= avs_writedata[3:0];
				default:      cfg_reg          <= cfg_reg;
			endcase
		end
	end

	// Port 0 speed: fallback to the strap when virtual negotiation fails
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			an_fail_reg  <= 1'b0;
			p0_speed_reg <= STRAP_RESET.speed0;
		end else begin
			an_fail_reg  <= vphy_an_fail;
			p0_speed_reg <= vphy_an_fail ? strap_reg.speed0 : vphy_an_speed_100;
		end
	end

	// Read decode; unmapped addresses read zero with a decode error
	always_comb begin
		hit     = 1'b1;
		rd_word = 32'h00000000;
		case (avs_address)
			OFS_BASIC:     rd_word = {29'h00000000, cfg_reg.basic};
			OFS_ADVERT:    rd_word = zext4(cfg_reg.advert);
			OFS_SPECIAL:   rd_word = {29'h00000000, cfg_reg.mode};
			OFS_PAUSE:     rd_word = zext4(cfg_reg.pause);
			OFS_VPARTNER:  rd_word = zext4(cfg_reg.vpartner);
			OFS_P0_STATUS: rd_word = {30'h00000000, an_fail_reg, p0_speed_reg};
			OFS_STRAPS:    rd_word = {22'h000000, hard_reg, 1'b0, strap_reg};
			default:       hit     = 1'b0;
		endcase
	end

	// One wait state: waitrequest drops for exactly one cycle per request
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h00000000;
			resp_reg  <= RESP_OK;
		end else if (req && wait_reg) begin
			wait_reg  <= 1'b0;
			rdata_reg <= (avs_read && hit) ? rd_word : 32'h00000000;
			resp_reg  <= hit ? RESP_OK : RESP_DECERR;
		end else begin
			wait_reg  <= 1'b1;
			rdata_reg <= rdata_reg;
			resp_reg  <= resp_reg;
		end
	end

	// Outputs straight from flops
	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign avs_response    = resp_reg;
	assign cfg_out         = cfg_reg;
	assign hard_out        = hard_reg;
	assign p0_speed_100    = p0_speed_reg;

	// Checks; antecedents also test reset, since release lands on the very edge an attempt starts
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	// Speed low bit
	a_speed_low_load: assert property (!reset && load |=>
		cfg_reg.basic[BASIC_SPEED] == ($past(map_in.speed2) | $past(map_in.autoneg2)))
		else $error("speed low bit default wrong");

	// Ten-meg half advertisement
	a_ten_adv_load: assert property (!reset && load |=>
		cfg_reg.advert[ADV_10HD] == ($past(map_in.autoneg2) | ~$past(map_in.speed2)))
		else $error("ten-meg half advertisement default wrong");

	// Forced 100 mode codes
	a_mode_fast_load: assert property (!reset && load && !map_in.autoneg2 && map_in.speed2 |=>
		cfg_reg.mode == ($past(map_in.duplex2) ? MODE_100FD : MODE_100HD))
		else $error("forced 100 mode code wrong");

	// Forced 10 mode codes
	a_mode_slow_load: assert property (!reset && load && !map_in.autoneg2 && !map_in.speed2 |=>
		cfg_reg.mode == ($past(map_in.duplex2) ? MODE_10FD : MODE_10HD))
		else $error("forced 10 mode code wrong");

	// All-capable mode under auto-negotiation
	a_mode_an_load: assert property (!reset && load && map_in.autoneg2 |=>
		cfg_reg.mode == MODE_AN_ALL)
		else $error("mode not all-capable with auto-negotiation strap");

	// Auto-negotiation enable bit
	a_an_enable_load: assert property (!reset && load |=>
		cfg_reg.basic[BASIC_AN_EN] == $past(map_in.autoneg2))
		else $error("auto-negotiation enable default wrong");

	// Forced 100 duplex follows the duplex strap
	a_mode_forced: assert property (!reset && load && !map_in.autoneg2 && map_in.speed2 |=>
		cfg_reg.mode[1] && cfg_reg.mode[0] == $past(map_in.duplex2))
		else $error("forced mode does not follow duplex strap");

	// Duplex bit
	a_duplex_load: assert property (!reset && load |=>
		cfg_reg.basic[BASIC_DUPLEX] == ($past(map_in.duplex2) | $past(map_in.autoneg2)))
		else $error("duplex bit default wrong");

	// Ten-meg full advertisement needs the duplex strap
	a_ten_full_load: assert property (!reset && load |=>
		cfg_reg.advert[ADV_10FD] == (($past(map_in.autoneg2) | ~$past(map_in.speed2)) & $past(map_in.duplex2)))
		else $error("ten-meg full advertisement default wrong");

	// Backpressure enable
	a_backpress_load: assert property (!reset && load |=>
		cfg_reg.pause[PAUSE_BP] == $past(map_in.bp2))
		else $error("backpressure default wrong");

	// Both pause enables
	a_pause_en_load: assert property (!reset && load |=>
		cfg_reg.pause[PAUSE_TX] == $past(map_in.fdfc2) && cfg_reg.pause[PAUSE_RX] == $past(map_in.fdfc2))
		else $error("pause enable defaults wrong");

	// Asymmetric pause advertisement
	a_asym_adv_load: assert property (!reset && load |=>
		cfg_reg.advert[ADV_ASYM] == ($past(map_in.fdfc2) & ~$past(map_in.manfc2)))
		else $error("asymmetric pause advertisement wrong");

	// Manual select, never together with symmetric pause
	a_manual_load: assert property (!reset && load |=>
		cfg_reg.pause[PAUSE_MANUAL] == $past(map_in.manfc2) && (!cfg_reg.pause[PAUSE_MANUAL] || !cfg_reg.advert[ADV_SYM]))
		else $error("manual flow control default wrong");

	// Symmetric pause advertisement
	a_sym_adv_load: assert property (!reset && load |=>
		cfg_reg.advert[ADV_SYM] == ($past(map_in.fdfc2) & ~$past(map_in.manfc2)))
		else $error("symmetric pause advertisement wrong");

	// Partner 100 abilities
	a_partner_load: assert property (!reset && load |=>
		cfg_reg.vpartner[VP_100FD] == $past(map_in.speed0) && cfg_reg.vpartner[VP_100HD] == $past(map_in.speed0))
		else $error("virtual partner ability default wrong");

	// Partner ten-meg abilities always offered
	a_partner_ten: assert property (!reset && load |=>
		cfg_reg.vpartner[VP_10FD] && cfg_reg.vpartner[VP_10HD])
		else $error("virtual partner ten-meg ability missing");

	// Fallback takes the strapped speed
	a_fallback_speed: assert property (!reset && vphy_an_fail |=>
		p0_speed_100 == $past(strap_reg.speed0))
		else $error("port 0 fallback speed not from strap");

	// Negotiated speed passes through when not failed
	a_follow_speed: assert property (!reset && !vphy_an_fail |=>
		p0_speed_100 == $past(vphy_an_speed_100))
		else $error("port 0 negotiated speed not followed");

	// Failure flag tracks its input
	a_fail_status: assert property (!reset |=>
		an_fail_reg == $past(vphy_an_fail))
		else $error("port 0 failure status wrong");

	// Pins captured at the first edge after reset
	a_pins_first: assert property (!reset && pending_reg |=>
		strap_reg == $past(strap_pins) && hard_out == $past(hard_pins))
		else $error("strap pins not captured after reset");

	// Loader replaces the soft straps
	a_eeprom_soft: assert property (!reset && eeprom_valid && !pending_reg |=>
		strap_reg == $past(eeprom_straps))
		else $error("loader straps not taken");

	// Hard straps hold after capture
	a_hard_held: assert property (!reset && !pending_reg |=>
		$stable(hard_out))
		else $error("hard strap changed after reset");

	// Status and strap words are read only
	a_ro_write: assert property (!reset && wr_commit && !load && (avs_address == OFS_STRAPS || avs_address == OFS_P0_STATUS) |=>
		$stable(cfg_reg) && $stable(strap_reg))
		else $error("read-only word changed by a write");

	// A software write to the pause register lands and holds one more cycle unless a load comes
	a_write_kept: assert property (!reset && wr_commit && lane0 && !load && avs_address == OFS_PAUSE |=>
		cfg_reg.pause == $past(avs_writedata[3:0]) ##1 ($past(load) || $stable(cfg_reg.pause)))
		else $error("software write to pause register lost");

	// Nothing moves without a load or a write
	a_no_load_hold: assert property (!reset && !load && !wr_commit |=>
		$stable(cfg_reg))
		else $error("register changed without load or write");

	// Writes without the low byte lane are refused
	a_lane_refused: assert property (!reset && wr_commit && !lane0 && !load |=>
		$stable(cfg_reg))
		else $error("write without low lane took effect");

	// One wait state per request
	a_wait_answer: assert property (!reset && req && wait_reg |=>
		!avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest not one cycle low");

	// Idle bus keeps waitrequest high
	a_idle_wait: assert property (!reset && !req |=>
		avs_waitrequest)
		else $error("waitrequest low without a request");

	// Read answer carries the addressed word
	a_read_data: assert property (!reset && avs_read && wait_reg && hit |=>
		avs_readdata == $past(rd_word) && avs_response == RESP_OK)
		else $error("read answer wrong");

	// Unmapped access answers with a decode error
	a_decode_error: assert property (!reset && req && wait_reg && !hit |=>
		avs_readdata == 32'h00000000 && avs_response == RESP_DECERR)
		else $error("decode error answer wrong");

	// Write answers return zero data
	a_write_zero: assert property (!reset && avs_write && wait_reg |=>
		avs_readdata == 32'h00000000)
		else $error("write answer data not zero");

	// Main scenarios
	c_eeprom_load: cover property (!pending_reg && eeprom_valid ##1 cfg_reg != CFG_RESET);
	c_sw_write: cover property (wr_commit && avs_address == OFS_BASIC);
	c_fallback: cover property (vphy_an_fail ##1 !p0_speed_100);
	c_decode_err: cover property (avs_response == RESP_DECERR);
	c_forced_mode: cover property (!reset && load && !map_in.autoneg2);

endmodule

// file: verilog/psd_pkg.sv
// Package holding register map, field layout, strap defaults and carrier types for the strap mapper
package psd_pkg;

	// Avalon word addresses of the registers
	localparam int          ADDR_W        = 4;
	localparam logic [3:0]  OFS_BASIC     = 4'h0;
	localparam logic [3:0]  OFS_ADVERT    = 4'h1;
	localparam logic [3:0]  OFS_SPECIAL   = 4'h2;
	localparam logic [3:0]  OFS_PAUSE     = 4'h3;
	localparam logic [3:0]  OFS_VPARTNER  = 4'h4;
	localparam logic [3:0]  OFS_P0_STATUS = 4'h5;
	localparam logic [3:0]  OFS_STRAPS    = 4'h6;

	// Basic control fields
	localparam int BASIC_AN_EN  = 0;
	localparam int BASIC_SPEED  = 1;
	localparam int BASIC_DUPLEX = 2;
	// Advertisement fields
	localparam int ADV_10HD     = 0;
	localparam int ADV_10FD     = 1;
	localparam int ADV_SYM      = 2;
	localparam int ADV_ASYM     = 3;
	// Port 2 pause control fields
	localparam int PAUSE_BP     = 0;
	localparam int PAUSE_MANUAL = 1;
	localparam int PAUSE_TX     = 2;
	localparam int PAUSE_RX     = 3;
	// Virtual partner ability fields
	localparam int VP_10HD      = 0;
	localparam int VP_10FD      = 1;
	localparam int VP_100HD     = 2;
	localparam int VP_100FD     = 3;
	// Port 0 status fields
	localparam int P0_SPEED_100 = 0;
	localparam int P0_AN_FAIL   = 1;
	// Strap register: soft straps in 6:0, hard straps in 9:8
	localparam int STRAP_HARD_LO = 8;

	// Port 2 mode field codes
	localparam logic [2:0] MODE_10HD    = 3'h0;
	localparam logic [2:0] MODE_10FD    = 3'h1;
	localparam logic [2:0] MODE_100HD   = 3'h2;
	localparam logic [2:0] MODE_100FD   = 3'h3;
	localparam logic [2:0] MODE_AN_ALL  = 3'h7;

	// Avalon response codes
	localparam logic [1:0] RESP_OK      = 2'h0;
	localparam logic [1:0] RESP_DECERR  = 2'h3;

	// Soft strap set, one bit per strap
	typedef struct packed {
		logic speed0;
		logic manfc2;
		logic fdfc2;
		logic bp2;
		logic duplex2;
		logic autoneg2;
		logic speed2;
	} psd_strap_t;

	// Register contents that straps give defaults to
	typedef struct packed {
		logic [2:0] basic;
		logic [3:0] advert;
		logic [2:0] mode;
		logic [3:0] pause;
		logic [3:0] vpartner;
	} psd_cfg_t;

	// Strap values when nothing drives them
	localparam psd_strap_t STRAP_RESET = '{speed0: 1'b1, manfc2: 1'b0, fdfc2: 1'b1, bp2: 1'b1,
		duplex2: 1'b1, autoneg2: 1'b1, speed2: 1'b1};
	localparam logic [1:0] HARD_RESET  = 2'h0;

	// Register contents that those strap values give
	localparam psd_cfg_t CFG_RESET = '{basic: 3'h7, advert: 4'hf, mode: 3'h7, pause: 4'hd, vpartner: 4'hf};

endpackage

// file: verilog/psd_default_map.sv
// Combinational mapping from a soft strap set to register default values
module psd_default_map (
	input  wire psd_pkg::psd_strap_t straps,
	output psd_pkg::psd_cfg_t        dflt
);
	import psd_pkg::*;

	// Mode code for a forced link
	function automatic logic [2:0] forced_mode(input logic spd, input logic dpx);
		logic [2:0] m;
		m = spd ? (dpx ? MODE_100FD : MODE_100HD) : (dpx ? MODE_10FD : MODE_10HD);
		return m;
	endfunction

	logic ten_adv;
	logic sym_adv;

	// Ten-meg abilities stay advertised with auto-negotiation on; forced 100 drops them
	assign ten_adv = straps.autoneg2 | ~straps.speed2;
	// Manual flow control withholds both pause abilities
	assign sym_adv = straps.fdfc2 & ~straps.manfc2;

	// Basic control: auto-negotiation start forces speed and duplex bits high
	assign dflt.basic[BASIC_AN_EN]  = straps.autoneg2;
	assign dflt.basic[BASIC_SPEED]  = straps.speed2 | straps.autoneg2;
	assign dflt.basic[BASIC_DUPLEX] = straps.duplex2 | straps.autoneg2;

	// Advertisement bits
	assign dflt.advert[ADV_10HD] = ten_adv;
	assign dflt.advert[ADV_10FD] = ten_adv & straps.duplex2;
	assign dflt.advert[ADV_SYM]  = sym_adv;
	assign dflt.advert[ADV_ASYM] = sym_adv;

	// Mode field
	assign dflt.mode = straps.autoneg2 ? MODE_AN_ALL : forced_mode(straps.speed2, straps.duplex2);

	// Port 2 pause control
	assign dflt.pause[PAUSE_BP]     = straps.bp2;
	assign dflt.pause[PAUSE_MANUAL] = straps.manfc2;
	assign dflt.pause[PAUSE_TX]     = straps.fdfc2;
	assign dflt.pause[PAUSE_RX]     = straps.fdfc2;

	// Virtual partner: 100 abilities only with the port 0 speed strap high
	assign dflt.vpartner[VP_10HD]  = 1'b1;
	assign dflt.vpartner[VP_10FD]  = 1'b1;
	assign dflt.vpartner[VP_100HD] = straps.speed0;
	assign dflt.vpartner[VP_100FD] = straps.speed0;

endmodule

// file: test/psd_strap_source.sv
// Partner model: strap pins with their pull levels and the EEPROM loader strobe
module psd_strap_source (
	input  wire logic                clk_sys,
	input  wire logic                drive_en,
	input  wire psd_pkg::psd_strap_t pin_val,
	input  wire logic                load_go,
	input  wire psd_pkg::psd_strap_t load_val,
	output psd_pkg::psd_strap_t      strap_pins,
	output logic                     eeprom_valid,
	output psd_pkg::psd_strap_t      eeprom_straps
);
	timeunit 1ns;
	timeprecision 100ps;
	import psd_pkg::*;

	// Undriven pins settle to their pull levels, the documented defaults
	assign strap_pins = drive_en ? pin_val : STRAP_RESET;

	// Loader strobe lasts one cycle; data turn stale right after it so a late sample shows up
	always_ff @(posedge clk_sys) begin
		eeprom_valid <= load_go;
		if (load_go) begin
			eeprom_straps <= load_val;
		end else begin
			eeprom_straps <= ~eeprom_straps;
		end
	end
endmodule

// file: test/port_strap_default_mapper_tb_top.sv
// Testbench for the strap default mapper: defaults, software writes, loads and fallback
module port_strap_default_mapper_tb_top import psd_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic        drive_en = 1'b0;
	logic        load_go = 1'b0;
	logic        eeprom_valid;
	logic        vphy_an_fail = 1'b0;
	logic        vphy_an_speed_100 = 1'b0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic        avs_waitrequest;
	logic        p0_speed_100;
	logic [1:0]  hard_pins = 2'h2;
	logic [1:0]  avs_response;
	logic [1:0]  hard_out;
	logic [1:0]  rs;
	logic [3:0]  avs_address = 4'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic [31:0] rd;
	psd_strap_t  strap_pins;
	psd_strap_t  eeprom_straps;
	psd_strap_t  pin_val = 7'h00;
	psd_strap_t  load_val = 7'h00;
	psd_cfg_t    cfg_out;
	psd_cfg_t    exp_cfg;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	// Three forced modes first, last entry leaves the port 0 speed strap low
	psd_strap_t  pats [6] = '{7'h00, 7'h01, 7'h05, 7'h22, 7'h58, 7'h04};

	psd_strap_source partner (.clk_sys(clk_sys), .drive_en(drive_en), .pin_val(pin_val), .load_go(load_go),
		.load_val(load_val), .strap_pins(strap_pins), .eeprom_valid(eeprom_valid), .eeprom_straps(eeprom_straps));

	psd_strap_mapper uut (.clk_sys(clk_sys), .reset(reset), .strap_pins(strap_pins), .hard_pins(hard_pins),
		.eeprom_valid(eeprom_valid), .eeprom_straps(eeprom_straps), .vphy_an_fail(vphy_an_fail),
		.vphy_an_speed_100(vphy_an_speed_100), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.cfg_out(cfg_out), .hard_out(hard_out), .p0_speed_100(p0_speed_100));

	// 20 MHz system clock
	always #25 clk_sys = ~clk_sys;

	// Watchdog, well above the few hundred cycles the tests need
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 1000) begin
			error_cnt++;
			complete_run();
		end
	end

	// Register contents a strap set should give, worked out independently of the design
	function automatic psd_cfg_t map_exp(input psd_strap_t s);
		psd_cfg_t c;
		logic     hd;
		hd = s.autoneg2 | ~s.speed2;
		c.basic = {s.duplex2 | s.autoneg2, s.speed2 | s.autoneg2, s.autoneg2};
		c.advert = {{2{s.fdfc2 & ~s.manfc2}}, hd & s.duplex2, hd};
		c.mode = s.autoneg2 ? MODE_AN_ALL : {1'b0, s.speed2, s.duplex2};
		c.pause = {s.fdfc2, s.fdfc2, s.manfc2, s.bp2};
		c.vpartner = {s.speed0, s.speed0, 2'b11};
		return c;
	endfunction

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask

	// Bus cycle: hold the request until waitrequest is sampled low, then release
	task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be);
		avs_address <= a;
		avs_writedata <= wd;
		avs_byteenable <= be;
		avs_read <= ~wr;
		avs_write <= wr;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		rs = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
		bus_xfer(1'b0, a, 32'h0, 4'hf);
		chk("read data", e, rd);
		chk("read response", {30'h0, r}, {30'h0, rs});
	endtask

	task automatic check_regs(input psd_cfg_t e);
		rd_chk(OFS_BASIC, {29'h0, e.basic}, RESP_OK);
		rd_chk(OFS_ADVERT, {28'h0, e.advert}, RESP_OK);
		rd_chk(OFS_SPECIAL, {29'h0, e.mode}, RESP_OK);
		rd_chk(OFS_PAUSE, {28'h0, e.pause}, RESP_OK);
		rd_chk(OFS_VPARTNER, {28'h0, e.vpartner}, RESP_OK);
	endtask

	// Two cycles of reset, then the capture edge and one spare edge
	task automatic do_reset();
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		// Undriven pins give the pull-level defaults
		do_reset();
		chk("cfg_out", 32'(map_exp(STRAP_RESET)), 32'(cfg_out));
		check_regs(map_exp(STRAP_RESET));
		rd_chk(OFS_STRAPS, {22'h0, 2'h2, 1'b0, STRAP_RESET}, RESP_OK);
		$display("test defaults done");

		// Software writes take effect; refused writes leave the registers alone
		bus_xfer(1'b1, OFS_PAUSE, 32'h0, 4'hf);
		rd_chk(OFS_PAUSE, 32'h0, RESP_OK);
		bus_xfer(1'b1, OFS_BASIC, 32'h0, 4'he);
		rd_chk(OFS_BASIC, 32'h7, RESP_OK);
		bus_xfer(1'b1, OFS_STRAPS, 32'h0, 4'hf);
		rd_chk(OFS_STRAPS, {22'h0, 2'h2, 1'b0, STRAP_RESET}, RESP_OK);
		rd_chk(4'hf, 32'h0, RESP_DECERR);
		$display("test writes done");

		// EEPROM load replaces soft straps only, hard pins change but are not taken
		hard_pins <= 2'h1;
		load_val <= 7'h45;
		load_go <= 1'b1;
		@(posedge clk_sys);
		load_go <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("cfg_out", 32'(map_exp(7'h45)), 32'(cfg_out));
		chk("hard_out", 32'h2, {30'h0, hard_out});
		rd_chk(OFS_STRAPS, {22'h0, 2'h2, 1'b0, 7'h45}, RESP_OK);
		$display("test eeprom done");

		// Each strap pattern after a reset, driven pins win over the earlier load
		drive_en <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			pin_val <= pats[i];
			do_reset();
			exp_cfg = map_exp(pats[i]);
			chk("cfg_out", 32'(exp_cfg), 32'(cfg_out));
			check_regs(exp_cfg);
			rd_chk(OFS_SPECIAL, {29'h0, exp_cfg.mode}, RESP_OK);
			rd_chk(OFS_STRAPS, {22'h0, 2'h1, 1'b0, pats[i]}, RESP_OK);
		end
		$display("test patterns done");

		// Failed negotiation falls back to the strapped port 0 speed, here 10
		vphy_an_fail <= 1'b1;
		vphy_an_speed_100 <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk("p0_speed_100", 32'h0, {31'h0, p0_speed_100});
		rd_chk(OFS_P0_STATUS, 32'h2, RESP_OK);
		vphy_an_fail <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("p0_speed_100", 32'h1, {31'h0, p0_speed_100});
		$display("test fallback done");
		complete_run();
	end
endmodule
